// [rtl/lpm_poll_pkg.sv]
package lpm_poll_pkg;
   // frame layout
   localparam int FRAME_BITS     = 32;
   localparam int ADDR_W         = 7;
   localparam int DATA_W         = 24;
   localparam int ADDR_MSB       = 31;
   localparam int ADDR_LSB       = 25;
   localparam int RW_BIT         = 24;
   localparam int FAULT_BIT      = 23;
   localparam int INT_BIT        = 22;
   localparam int CNT_W          = 6;
   // register addresses
   localparam logic [6:0] ADDR_PROG_SLOW = 7'h18;
   localparam logic [6:0] ADDR_GND_SLOW  = 7'h19;
   localparam logic [6:0] ADDR_PROG_DEB  = 7'h1a;
   localparam logic [6:0] ADDR_GND_DEB   = 7'h1b;
   // channel counts and field masks
   localparam int PROG_CH        = 12;
   localparam int GND_CH         = 21;
   localparam int ALL_CH         = 33;
   localparam logic [21:0] PROG_MASK = 22'h000fff;
   localparam logic [21:0] GND_MASK  = 22'h1fffff;
   localparam logic [21:0] REG_RESET = 22'h000000;
   // polling timing
   localparam int SLOW_DIV        = 4;
   localparam int MCLK_PERIOD_NS  = 5;
   localparam int DEB_EXT_NS      = 1200000;
   localparam int DEB_EXT_CYCLES  = DEB_EXT_NS / MCLK_PERIOD_NS;
   localparam int POLL_PULSE_CYC  = 16;
endpackage

// [rtl/spi_frame_if.sv]
`timescale 1ns/10ps
interface spi_frame_if;
   logic        frame_done;
   logic [31:0] rx_word;
   logic [31:0] tx_word;
   modport shifter
   (
      output frame_done,
      output rx_word,
      input  tx_word
   );
   modport core
   (
      input  frame_done,
      input  rx_word,
      output tx_word
   );
endinterface

// [rtl/spi_frame_shifter.sv]
`timescale 1ns/10ps
module spi_frame_shifter
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // spi pins
   input  wire logic          sclk,
   input  wire logic          cs_n,
   input  wire logic          mosi,
   output      logic          miso,
   output      logic          miso_oe,
   // frame side
   spi_frame_if.shifter       frm
);
   logic                            sclk_d;
   logic                            cs_n_d;
   logic [lpm_poll_pkg::CNT_W-1:0]  bit_cnt;
   logic [31:0]                     rx_shift;
   logic [31:0]                     tx_shift;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end
      else
      begin
         sclk_d <= sclk;
         cs_n_d <= cs_n;
      end
   end

   // receive: sample mosi on rising sclk, msb first
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt  <= '0;
         rx_shift <= '0;
      end
      else if (cs_n)
         bit_cnt <= '0;
      else if (sclk && !sclk_d)
      begin
         rx_shift <= {rx_shift[30:0], mosi};
         if (bit_cnt <= lpm_poll_pkg::CNT_W'(lpm_poll_pkg::FRAME_BITS))
            bit_cnt <= bit_cnt + 1'b1;
      end
   end

   // only frames of exactly 32 clocks are handed on
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         frm.frame_done <= 1'b0;
         frm.rx_word    <= '0;
      end
      else
      begin
         frm.frame_done <= cs_n && !cs_n_d &&
            bit_cnt == lpm_poll_pkg::CNT_W'(lpm_poll_pkg::FRAME_BITS);
         if (cs_n && !cs_n_d)
            frm.rx_word <= rx_shift;
      end
   end

   // transmit: load at select, shift on falling sclk
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tx_shift <= '0;
         miso     <= 1'b0;
         miso_oe  <= 1'b0;
      end
      else
      begin
         miso_oe <= !cs_n;
         if (!cs_n && cs_n_d)
         begin
            tx_shift <= {frm.tx_word[30:0], 1'b0};
            miso     <= frm.tx_word[31];
         end
         else if (!cs_n && !sclk && sclk_d)
         begin
            tx_shift <= {tx_shift[30:0], 1'b0};
            miso     <= tx_shift[31];
         end
      end
   end
endmodule

// [rtl/poll_scheduler.sv]
`timescale 1ns/10ps
module poll_scheduler
#(
   parameter int N = 33
)
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // control
   input  wire logic          low_power_state,
   input  wire logic          base_poll_tick,
   input  wire logic [N-1:0]  slow_poll,
   // per-channel poll request
   output      logic [N-1:0]  poll_due
);
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : chan
         logic [1:0] div;
         // divide the base tick by four for slow channels
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               div         <= 2'h0;
               poll_due[g] <= 1'b0;
            end
            else if (!low_power_state)
            begin
               div         <= 2'h0;
               poll_due[g] <= 1'b0;
            end
            else
            begin
               poll_due[g] <= base_poll_tick &&
                  (!slow_poll[g] || div == 2'h0);
               if (base_poll_tick)
                  div <= div + 2'h1;
            end
         end
      end
   endgenerate
endmodule

// [rtl/lpm_poll_config_regs.sv]
`timescale 1ns/10ps
// Summary of operation
// - Address 0x18 holds a read/write slow-poll bit for each of the 12 programmable channels in bits 11..0, cleared at power-on.
// - Address 0x19 holds a read/write slow-poll bit for each of the 21 ground-switch channels in bits 20..0, cleared at power-on.
// - Address 0x1a holds a read/write wake debounce bit for each programmable channel in bits 11..0, cleared at power-on.
// - Address 0x1b holds a read/write wake debounce bit for each ground-switch channel in bits 20..0, cleared at power-on.
// - The base polling interval comes from the separate low-power configuration, arriving here as a base tick.
// - A channel whose slow-poll bit is clear is polled on every base tick while in the low-power state.
// - A channel whose slow-poll bit is set is polled on every fourth base tick only.
// - A channel whose debounce bit is clear is judged by voltage difference at the end of the plain current pulse.
// - A channel whose debounce bit is set keeps its polling current for 1.2 ms more and is judged by the final level.
// - Every response word carries the fault indication in bit 23, the interrupt flag in bit 22 and register data below.
// - Leaving the low-power state leaves every configuration bit as it was written.
module lpm_poll_config_regs
#(
   parameter int POLL_PULSE_CYCLES = lpm_poll_pkg::POLL_PULSE_CYC,
   parameter int DEB_EXT_CYCLES    = lpm_poll_pkg::DEB_EXT_CYCLES
)
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // spi pins
   input  wire logic          sclk,
   input  wire logic          cs_n,
   input  wire logic          mosi,
   output      logic          miso,
   output      logic          miso_oe,
   // device status
   input  wire logic          fault_status,
   input  wire logic          interrupt_flag,
   // low-power control
   input  wire logic          low_power_state,
   input  wire logic          base_poll_tick,
   // polling front end, ground channels in 20..0, programmable above
   output      logic [32:0]   poll_due,
   output      logic [32:0]   poll_current_on,
   output      logic [32:0]   sample_strobe,
   output      logic [32:0]   sample_by_level,
   // configuration readout
   output      logic [21:0]   prog_chan_slow_poll,
   output      logic [21:0]   gnd_chan_slow_poll,
   output      logic [21:0]   prog_chan_wake_debounce,
   output      logic [21:0]   gnd_chan_wake_debounce
);
   typedef enum logic [1:0] {poll_idle, poll_pulse, poll_extend} poll_type;

   spi_frame_if frm ();

   logic [6:0]   cmd_addr;
   logic         cmd_write;
   logic [21:0]  cmd_data;
   logic [32:0]  slow_all;
   logic [32:0]  deb_all;
   logic [32:0]  poll_mask;
   logic [31:0]  timer;
   poll_type     poll_state;
   logic [31:0]  resp_word;

   assign cmd_addr  = frm.rx_word[lpm_poll_pkg::ADDR_MSB:lpm_poll_pkg::ADDR_LSB];
   assign cmd_write = frm.rx_word[lpm_poll_pkg::RW_BIT];
   assign cmd_data  = frm.rx_word[21:0];
   assign slow_all  = {prog_chan_slow_poll[11:0], gnd_chan_slow_poll[20:0]};
   assign deb_all   = {prog_chan_wake_debounce[11:0],
                       gnd_chan_wake_debounce[20:0]};
   assign frm.tx_word = resp_word;

   // read data of an address, zero for unused bits and unknown addresses
   function automatic logic [21:0] read_data(input logic [6:0] a);
      logic [21:0] d;
      d = 22'h000000;
      if (a == lpm_poll_pkg::ADDR_PROG_SLOW)
         d = prog_chan_slow_poll;
      else if (a == lpm_poll_pkg::ADDR_GND_SLOW)
         d = gnd_chan_slow_poll;
      else if (a == lpm_poll_pkg::ADDR_PROG_DEB)
         d = prog_chan_wake_debounce;
      else if (a == lpm_poll_pkg::ADDR_GND_DEB)
         d = gnd_chan_wake_debounce;
      return d;
   endfunction

   spi_frame_shifter u_shift
   (
      .mclk     (mclk),
      .rst      (rst),
      .sclk     (sclk),
      .cs_n     (cs_n),
      .mosi     (mosi),
      .miso     (miso),
      .miso_oe  (miso_oe),
      .frm      (frm)
   );

   poll_scheduler #(.N(lpm_poll_pkg::ALL_CH)) u_sched
   (
      .mclk             (mclk),
      .rst              (rst),
      .low_power_state  (low_power_state),
      .base_poll_tick   (base_poll_tick),
      .slow_poll        (slow_all),
      .poll_due         (poll_due)
   );

   // register writes; nothing here reacts to the low-power state
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prog_chan_slow_poll     <= lpm_poll_pkg::REG_RESET;
         gnd_chan_slow_poll      <= lpm_poll_pkg::REG_RESET;
         prog_chan_wake_debounce <= lpm_poll_pkg::REG_RESET;
         gnd_chan_wake_debounce  <= lpm_poll_pkg::REG_RESET;
      end
      else if (frm.frame_done && cmd_write)
      begin
         if (cmd_addr == lpm_poll_pkg::ADDR_PROG_SLOW)
            prog_chan_slow_poll <= cmd_data & lpm_poll_pkg::PROG_MASK;
         else if (cmd_addr == lpm_poll_pkg::ADDR_GND_SLOW)
            gnd_chan_slow_poll <= cmd_data & lpm_poll_pkg::GND_MASK;
         else if (cmd_addr == lpm_poll_pkg::ADDR_PROG_DEB)
            prog_chan_wake_debounce <= cmd_data & lpm_poll_pkg::PROG_MASK;
         else if (cmd_addr == lpm_poll_pkg::ADDR_GND_DEB)
            gnd_chan_wake_debounce <= cmd_data & lpm_poll_pkg::GND_MASK;
      end
   end

   // response for the frame just taken, shifted out in the next frame
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         resp_word <= '0;
      else if (frm.frame_done)
         resp_word <= {cmd_addr, 1'b0, fault_status, interrupt_flag,
                       cmd_write ? cmd_data & mask_of(cmd_addr)
                                 : read_data(cmd_addr)};
   end

   // mask of writable bits for an address
   function automatic logic [21:0] mask_of(input logic [6:0] a);
      logic [21:0] m;
      m = 22'h000000;
      if (a == lpm_poll_pkg::ADDR_PROG_SLOW || a == lpm_poll_pkg::ADDR_PROG_DEB)
         m = lpm_poll_pkg::PROG_MASK;
      else if (a == lpm_poll_pkg::ADDR_GND_SLOW ||
               a == lpm_poll_pkg::ADDR_GND_DEB)
         m = lpm_poll_pkg::GND_MASK;
      return m;
   endfunction

   // polling current pulse, optional extension, then sampling
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         poll_state      <= poll_idle;
         timer           <= '0;
         poll_mask       <= '0;
         poll_current_on <= '0;
         sample_strobe   <= '0;
         sample_by_level <= '0;
      end
      else if (!low_power_state)
      begin
         poll_state      <= poll_idle;
         poll_current_on <= '0;
         sample_strobe   <= '0;
      end
      else
      begin
         sample_strobe <= '0;
         case (poll_state)
            poll_idle:
               if (|poll_due)
               begin
                  poll_mask       <= poll_due;
                  poll_current_on <= poll_due;
                  timer           <= 32'(POLL_PULSE_CYCLES - 1);
                  poll_state      <= poll_pulse;
               end
            poll_pulse:
               if (timer != 0)
                  timer <= timer - 1'b1;
               else
               begin
                  sample_strobe   <= poll_mask & ~deb_all;
                  sample_by_level <= '0;
                  poll_current_on <= poll_mask & deb_all;
                  poll_mask       <= poll_mask & deb_all;
                  timer           <= 32'(DEB_EXT_CYCLES - 1);
                  poll_state      <= |(poll_mask & deb_all) ? poll_extend
                                                            : poll_idle;
               end
            poll_extend:
               if (timer != 0)
                  timer <= timer - 1'b1;
               else
               begin
                  sample_strobe   <= poll_mask;
                  sample_by_level <= poll_mask;
                  poll_current_on <= '0;
                  poll_state      <= poll_idle;
               end
            default:
               poll_state <= poll_idle;
         endcase
      end
   end

   // helper: base ticks seen since channel 0 was last polled
   logic [2:0] ticks_ch0;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ticks_ch0 <= 3'h3;
      else if (!low_power_state)
         ticks_ch0 <= 3'h3;
      else if (poll_due[0])
         ticks_ch0 <= base_poll_tick ? 3'h1 : 3'h0;
      else if (base_poll_tick && ticks_ch0 != 3'h7)
         ticks_ch0 <= ticks_ch0 + 3'h1;
   end

   property p_prog_slow_write;
      @(posedge mclk) disable iff (rst)
      frm.frame_done && cmd_write && cmd_addr == lpm_poll_pkg::ADDR_PROG_SLOW
      |=> prog_chan_slow_poll == ($past(cmd_data) & 22'h000fff);
   endproperty
   a_prog_slow_write: assert property (p_prog_slow_write)
      else $error("programmable slow-poll write not stored");

   property p_gnd_slow_write;
      @(posedge mclk) disable iff (rst)
      frm.frame_done && cmd_write && cmd_addr == lpm_poll_pkg::ADDR_GND_SLOW
      |=> gnd_chan_slow_poll == ($past(cmd_data) & 22'h1fffff);
   endproperty
   a_gnd_slow_write: assert property (p_gnd_slow_write)
      else $error("ground slow-poll write not stored");

   property p_prog_deb_write;
      @(posedge mclk) disable iff (rst)
      frm.frame_done && cmd_write && cmd_addr == lpm_poll_pkg::ADDR_PROG_DEB
      |=> prog_chan_wake_debounce == ($past(cmd_data) & 22'h000fff);
   endproperty
   a_prog_deb_write: assert property (p_prog_deb_write)
      else $error("programmable debounce write not stored");

   property p_gnd_deb_write;
      @(posedge mclk) disable iff (rst)
      frm.frame_done && cmd_write && cmd_addr == lpm_poll_pkg::ADDR_GND_DEB
      |=> gnd_chan_wake_debounce == ($past(cmd_data) & 22'h1fffff);
   endproperty
   a_gnd_deb_write: assert property (p_gnd_deb_write)
      else $error("ground debounce write not stored");

   property p_resp_status;
      @(posedge mclk) disable iff (rst)
      frm.frame_done |=> resp_word[23] == $past(fault_status)
         && resp_word[22] == $past(interrupt_flag)
         && resp_word[31:25] == $past(cmd_addr);
   endproperty
   a_resp_status: assert property (p_resp_status)
      else $error("response status bits wrong");

   property p_fast_poll;
      @(posedge mclk) disable iff (rst)
      low_power_state && base_poll_tick && !slow_all[0]
      ##1 low_power_state |-> poll_due[0];
   endproperty
   a_fast_poll: assert property (p_fast_poll)
      else $error("fast channel missed a base tick");

   property p_slow_poll;
      @(posedge mclk) disable iff (rst)
      low_power_state && slow_all[0] && $stable(slow_all[0]) && poll_due[0]
      |-> ticks_ch0 == 3'h4;
   endproperty
   a_slow_poll: assert property (p_slow_poll)
      else $error("slow channel not polled every fourth tick");

   property p_diff_sample;
      @(posedge mclk) disable iff (rst)
      low_power_state && poll_state == poll_pulse && timer == 0
      ##1 low_power_state
      |-> sample_strobe == $past(poll_mask & ~deb_all) && sample_by_level == 0;
   endproperty
   a_diff_sample: assert property (p_diff_sample)
      else $error("plain channels not sampled at pulse end");

   property p_extend_start;
      @(posedge mclk) disable iff (rst)
      low_power_state && poll_state == poll_pulse && timer == 0
      && |(poll_mask & deb_all) ##1 low_power_state
      |-> poll_state == poll_extend
         && timer == 32'(DEB_EXT_CYCLES - 1) && |poll_current_on;
   endproperty
   a_extend_start: assert property (p_extend_start)
      else $error("debounce extension not started");

   property p_level_sample;
      @(posedge mclk) disable iff (rst)
      low_power_state && poll_state == poll_extend && timer == 0
      ##1 low_power_state
      |-> sample_strobe == $past(poll_mask)
         && sample_by_level == $past(poll_mask) && poll_current_on == 0;
   endproperty
   a_level_sample: assert property (p_level_sample)
      else $error("extended channel not judged by level");

   property p_retain;
      @(posedge mclk) disable iff (rst)
      $fell(low_power_state) && !$past(frm.frame_done)
      |-> $stable(slow_all) && $stable(deb_all);
   endproperty
   a_retain: assert property (p_retain)
      else $error("configuration changed on leaving low power");

   property p_unused_zero;
      @(posedge mclk) disable iff (rst)
      prog_chan_slow_poll[21:12] == 0 && prog_chan_wake_debounce[21:12] == 0
      && gnd_chan_slow_poll[21] == 0 && gnd_chan_wake_debounce[21] == 0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused register bit set");
endmodule

// [bench/spi_host_model.sv]
`timescale 1ns/10ps
module spi_host_model
(
   // clock
   input  wire logic  mclk,
   // spi pins
   output      logic  sclk,
   output      logic  cs_n,
   output      logic  mosi,
   input  wire logic  miso
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   task automatic gap(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // msb-first frame of nbits clocks, response caught at rising sclk
   task automatic xfer(input logic [31:0] word, input int nbits,
                       output logic [31:0] got);
      got = 32'h0;
      gap(1);
      cs_n = 1'b0;
      for (int k = 0; k < nbits; k++)
      begin
         mosi = word[31-k];
         gap(4);
         sclk = 1'b1;
         got = {got[30:0], miso};
         gap(4);
         sclk = 1'b0;
      end
      gap(4);
      cs_n = 1'b1;
      // released line shows no stale level
      mosi = ~mosi;
      gap(8);
   endtask
endmodule

// [bench/lpm_poll_config_regs_tb_top.sv]
`timescale 1ns/10ps
module lpm_poll_config_regs_tb_top;
   localparam int P     = 4;
   localparam int E     = 20;
   localparam int LIMIT = 20000;
   logic        mclk, rst, sclk, cs_n, mosi, miso, miso_oe;
   logic        fault_status, interrupt_flag;
   logic        low_power_state, base_poll_tick;
   logic [32:0] poll_due, poll_current_on, sample_strobe, sample_by_level;
   logic [21:0] prog_chan_slow_poll, gnd_chan_slow_poll;
   logic [21:0] prog_chan_wake_debounce, gnd_chan_wake_debounce;
   logic [21:0] mdl [4];
   logic [31:0] exp_prev;
   logic        have_prev;
   integer      seed;
   int          bad_count, n_checks, cyc;
   int          due_cnt [33];
   int          due_at [33];
   int          on_cnt [33];
   logic        cs_n_q;
   logic [32:0] slow_v, deb_v;

   assign slow_v = {mdl[0][11:0], mdl[1][20:0]};
   assign deb_v  = {mdl[2][11:0], mdl[3][20:0]};

   lpm_poll_config_regs #(.POLL_PULSE_CYCLES(P), .DEB_EXT_CYCLES(E)) dut_u
   (
      .mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .fault_status(fault_status),
      .interrupt_flag(interrupt_flag), .low_power_state(low_power_state),
      .base_poll_tick(base_poll_tick), .poll_due(poll_due),
      .poll_current_on(poll_current_on), .sample_strobe(sample_strobe),
      .sample_by_level(sample_by_level),
      .prog_chan_slow_poll(prog_chan_slow_poll),
      .gnd_chan_slow_poll(gnd_chan_slow_poll),
      .prog_chan_wake_debounce(prog_chan_wake_debounce),
      .gnd_chan_wake_debounce(gnd_chan_wake_debounce)
   );

   spi_host_model host_u
   (
      .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso)
   );

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic [31:0] exp_word(input logic [6:0] a,
      input logic w, input logic [23:0] d, input logic f, input logic i);
      logic [21:0] v;
      v = 22'h0;
      if (a >= 7'h18 && a <= 7'h1b)
         v = w ? (d[21:0] & (a[0] ? lpm_poll_pkg::GND_MASK
                                  : lpm_poll_pkg::PROG_MASK)) : mdl[a[1:0]];
      return {a, 1'b0, f, i, v};
   endfunction

   task automatic frame(input logic [6:0] a, input logic w,
                        input logic [23:0] d, input int nbits);
      logic [31:0] got, nxt;
      fault_status = 1'($random(seed));
      interrupt_flag = 1'($random(seed));
      nxt = exp_word(a, w, d, fault_status, interrupt_flag);
      host_u.xfer({a, w, d}, nbits, got);
      if (nbits == 32)
      begin
         if (have_prev)
            check("response", got, exp_prev);
         exp_prev = nxt;
         have_prev = 1'b1;
         if (w && a >= 7'h18 && a <= 7'h1b)
            mdl[a[1:0]] = nxt[21:0];
      end
   endtask

   task automatic check_regs;
      check("prog slow", prog_chan_slow_poll, mdl[0]);
      check("gnd slow", gnd_chan_slow_poll, mdl[1]);
      check("prog deb", prog_chan_wake_debounce, mdl[2]);
      check("gnd deb", gnd_chan_wake_debounce, mdl[3]);
   endtask

   task automatic poll_run(input logic lp, input int ticks);
      for (int c = 0; c < 33; c++)
         due_cnt[c] = 0;
      low_power_state = lp;
      for (int t = 0; t < ticks; t++)
      begin
         @(negedge mclk);
         base_poll_tick = 1'b1;
         @(negedge mclk);
         base_poll_tick = 1'b0;
         repeat (P + E + 12) @(negedge mclk);
      end
      low_power_state = 1'b0;
      for (int c = 0; c < 33; c++)
         check("poll count", 32'(due_cnt[c]),
               !lp ? 32'h0 : slow_v[c] ? 32'((ticks + 3) / 4)
                                      : 32'(ticks));
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // poll monitor and run limit
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      cs_n_q <= cs_n;
      check("miso oe", miso_oe, !cs_n_q);
      if (cyc > LIMIT)
      begin
         bad_count++;
         test_done;
      end
      for (int c = 0; c < 33; c++)
      begin
         if (poll_due[c] === 1'b1)
         begin
            due_cnt[c]++;
            due_at[c] = cyc;
         end
         if (poll_current_on[c] === 1'b1)
            on_cnt[c]++;
         if (sample_strobe[c] === 1'b1)
         begin
            check("current time", 32'(on_cnt[c]),
                  deb_v[c] ? 32'(P + E) : 32'(P));
            on_cnt[c] = 0;
            check("sample kind", sample_by_level[c], deb_v[c]);
            check("sample delay", 32'(cyc - due_at[c]),
                  deb_v[c] ? 32'(1 + P + E) : 32'(1 + P));
         end
      end
   end

   initial
   begin
      seed = 32'h254027e9;
      cyc = 0;
      cs_n_q = 1'b1;
      bad_count = 0;
      n_checks = 0;
      have_prev = 1'b0;
      rst = 1'b1;
      fault_status = 1'b0;
      interrupt_flag = 1'b0;
      low_power_state = 1'b0;
      base_poll_tick = 1'b0;
      for (int i = 0; i < 4; i++)
         mdl[i] = lpm_poll_pkg::REG_RESET;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      check_regs;
      for (int i = 0; i < 4; i++)
         frame(7'h18 + 7'(i), 1'b0, 24'h0, 32);
      for (int i = 0; i < 4; i++)
         frame(7'h18 + 7'(i), 1'b1, 24'hffffff, 32);
      check_regs;
      // short frame must leave register and response alone
      frame(7'h18, 1'b1, 24'h000000, 31);
      frame(7'h18, 1'b0, 24'h0, 32);
      // unmapped places, incl. the low-power command
      frame(7'h1c, 1'b1, 24'h0, 32);
      frame(7'h7f, 1'b0, 24'h0, 32);
      repeat (14)
         frame(7'h18 | 7'($random(seed) & 3), 1'($random(seed)),
               24'($random(seed)), 32);
      check_regs;
      for (int i = 0; i < 4; i++)
         frame(7'h18 + 7'(i), 1'b1, 24'($random(seed)), 32);
      poll_run(1'b0, 3);
      poll_run(1'b1, 8);
      check_regs;
      // corner: channel 0 slow, channels 0 and 1 debounced
      frame(7'h19, 1'b1, 24'h000001, 32);
      frame(7'h1b, 1'b1, 24'h000003, 32);
      poll_run(1'b1, 4);
      for (int i = 0; i < 4; i++)
         frame(7'h18 + 7'(i), 1'b0, 24'h0, 32);
      frame(7'h7f, 1'b0, 24'h0, 32);
      test_done;
   end
endmodule
